// [pkg/csi_pkg.sv]
package csi_pkg;
  localparam logic [5:0] IO_SP_LOW = 6'h3d;
  localparam logic [5:0] IO_SP_HIGH = 6'h3e;
  localparam logic [5:0] IO_STATUS = 6'h3f;
  localparam logic [5:0] IO_CORE_CTRL = 6'h35;
  localparam int BIT_GIE = 7;
  localparam int BIT_SIGN = 4;
  localparam int BIT_OVF = 3;
  localparam int BIT_NEG = 2;
  localparam int BIT_ZERO = 1;
  localparam int BIT_CARRY = 0;
  localparam int BIT_VEC_RELOC = 1;
  localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h04ff;
  localparam logic [12:0] BOOT_START = 13'h1c00;
  localparam int NUM_IRQ = 8;
  localparam int PC_W = 13;
  localparam int ENTRY_CYCLES = 4;
  localparam int SLEEP_EXTRA_CYCLES = 4;
  localparam int RETURN_CYCLES = 4;
  localparam int REG_COUNT = 32;
  localparam logic [4:0] PTR_X_LOW = 5'h1a;
  localparam logic [4:0] PTR_Y_LOW = 5'h1c;
  localparam logic [4:0] PTR_Z_LOW = 5'h1e;
  typedef enum logic [2:0] {
    CSI_RUN = 3'b000,
    CSI_ENTRY = 3'b001,
    CSI_RETURN = 3'b011
  } csi_state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_PUSH = 3'h1,
    OP_POP = 3'h2,
    OP_CALL = 3'h3,
    OP_RET = 3'h4,
    OP_IRQ_RETURN_OP = 3'h5,
    OP_SEI = 3'h6,
    OP_CLI = 3'h7
  } csi_op_t;
  typedef enum logic [1:0] {
    PORT_R1_W8 = 2'h0,
    PORT_R2_W8 = 2'h1,
    PORT_R2_W16 = 2'h2,
    PORT_R1_W16 = 2'h3
  } csi_port_mode_t;
  typedef enum logic [1:0] {
    PTR_PLAIN = 2'h0,
    PTR_DISP = 2'h1,
    PTR_POST_INC = 2'h2,
    PTR_PRE_DEC = 2'h3
  } csi_ptr_mode_t;
endpackage

// [rtl/csi_regfile.sv]
`timescale 1ns/10ps
module csi_regfile
  import csi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire csi_port_mode_t i_port_mode,
  input wire logic [4:0] i_rd_a,
  input wire logic [4:0] i_rd_b,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_ptr_en,
  input wire logic [1:0] i_ptr_sel,
  input wire csi_ptr_mode_t i_ptr_mode,
  input wire logic [5:0] i_ptr_disp,
  output logic [15:0] o_rd_a,
  output logic [7:0] o_rd_b,
  output logic [15:0] o_ptr_addr
);
  // Registers are flops, not SRAM, so every port works in one cycle
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] r;
  } csi_rf_t;
  csi_rf_t st, next_st;
  logic [4:0] plo;
  logic [15:0] ptr;
  logic [15:0] ptr_new;

  function automatic logic [4:0] ptr_low(input logic [1:0] sel);
    case (sel)
      2'h0: ptr_low = PTR_X_LOW;
      2'h1: ptr_low = PTR_Y_LOW;
      default: ptr_low = PTR_Z_LOW;
    endcase
  endfunction

  always_comb begin
    plo = ptr_low(i_ptr_sel);
    ptr = {st.r[plo + 5'h01], st.r[plo]};
    ptr_new = ptr;
    o_ptr_addr = ptr;
    case (i_ptr_mode)
      PTR_DISP: o_ptr_addr = ptr + {10'h000, i_ptr_disp};
      PTR_POST_INC: ptr_new = ptr + 16'h0001;
      PTR_PRE_DEC: begin
        ptr_new = ptr - 16'h0001;
        o_ptr_addr = ptr_new;
      end
      default: ;
    endcase
    // Word reads use an even pair; single and dual byte modes read bytes
    case (i_port_mode)
      PORT_R1_W16: o_rd_a = {st.r[{i_rd_a[4:1], 1'b1}], st.r[{i_rd_a[4:1], 1'b0}]};
      default: o_rd_a = {8'h00, st.r[i_rd_a]};
    endcase
    o_rd_b = (i_port_mode == PORT_R2_W8 || i_port_mode == PORT_R2_W16) ?
      st.r[i_rd_b] : 8'h00;
    next_st = st;
    if (i_ptr_en && i_ptr_mode inside {PTR_POST_INC, PTR_PRE_DEC}) begin
      next_st.r[plo] = ptr_new[7:0];
      next_st.r[plo + 5'h01] = ptr_new[15:8];
    end
    if (i_wr_en) begin
      if (i_port_mode == PORT_R2_W16 || i_port_mode == PORT_R1_W16) begin
        next_st.r[{i_wr_addr[4:1], 1'b0}] = i_wr_data[7:0];
        next_st.r[{i_wr_addr[4:1], 1'b1}] = i_wr_data[15:8];
      end else begin
        next_st.r[i_wr_addr] = i_wr_data[7:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_ptr_postinc: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_ptr_en && i_ptr_mode == PTR_POST_INC && !i_wr_en) |=>
    ({st.r[$past(plo) + 5'h01], st.r[$past(plo)]} == $past(ptr) + 16'h0001))
    else $error("pointer post increment wrong");
  a_word_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_wr_en && i_port_mode == PORT_R1_W16) |=>
    (st.r[{$past(i_wr_addr[4:1]), 1'b1}] == $past(i_wr_data[15:8])))
    else $error("word write high byte lost");
endmodule

// [rtl/csi_core_ctrl.sv]
`timescale 1ns/10ps
module csi_core_ctrl
  import csi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_reset_vector_relocate_fuse,
  input wire logic i_alu_valid,
  input wire logic i_alu_arith,
  input wire logic [7:0] i_alu_result,
  input wire logic i_alu_carry,
  input wire logic i_alu_overflow,
  input wire logic i_insn_done,
  input wire logic i_sleeping,
  input wire csi_op_t i_op,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic [7:0] i_pop_data,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [5:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic [NUM_IRQ-1:0] i_irq_event,
  input wire logic [NUM_IRQ-1:0] i_irq_is_level,
  input wire logic [NUM_IRQ-1:0] i_irq_enable,
  input wire logic [NUM_IRQ-1:0] i_flag_clear_w1,
  input wire logic [15:0] i_data_addr,
  input wire csi_port_mode_t i_port_mode,
  input wire logic [4:0] i_rd_a,
  input wire logic [4:0] i_rd_b,
  input wire logic i_rf_wr,
  input wire logic [4:0] i_rf_waddr,
  input wire logic [15:0] i_rf_wdata,
  input wire logic i_ptr_en,
  input wire logic [1:0] i_ptr_sel,
  input wire csi_ptr_mode_t i_ptr_mode,
  input wire logic [5:0] i_ptr_disp,
  output logic [7:0] o_io_rdata,
  output logic [15:0] o_rd_a,
  output logic [7:0] o_rd_b,
  output logic [15:0] o_ptr_addr,
  output logic o_data_is_reg,
  output logic [15:0] o_stack_pointer,
  output logic o_stack_wr,
  output logic [15:0] o_stack_addr,
  output logic [7:0] o_stack_wdata,
  output logic o_stall,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_value,
  output logic [NUM_IRQ-1:0] o_irq_flags,
  output logic o_irq_ack,
  output logic [2:0] o_irq_ack_id
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    csi_state_t fsm;
    logic [3:0] cnt;
    logic [7:0] status;
    logic [15:0] sp;
    logic [7:0] core_ctrl;
    logic [NUM_IRQ-1:0] flags;
    logic hold_one;
    logic [2:0] irq_id;
    logic [PC_W-1:0] ret_pc;
    logic stack_wr;
    logic [15:0] stack_addr;
    logic [7:0] stack_wdata;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic irq_ack;
    logic [7:0] rdata;
    logic first;
  } csi_ctrl_t;
  csi_ctrl_t st, next_st;
  logic [NUM_IRQ-1:0] req;
  logic [NUM_IRQ-1:0] raw;
  logic take;
  logic [2:0] win;
  logic [3:0] entry_len;

  function automatic logic [2:0] lowest_set(input logic [NUM_IRQ-1:0] v);
    lowest_set = 3'h0;
    for (int k = NUM_IRQ - 1; k >= 0; k--) begin
      if (v[k]) begin
        lowest_set = k[2:0];
      end
    end
  endfunction

  // Source vectors are four words apart, starting at word 2; word 0 is reset
  function automatic logic [PC_W-1:0] vector_of(input logic [2:0] id, input logic reloc);
    logic [PC_W-1:0] base;
    base = reloc ? BOOT_START : '0;
    // Source 7 must not wrap, so the slot offset is built without a carry
    vector_of = base + {{(PC_W - 5){1'b0}}, id, 2'b10};
  endfunction

  csi_regfile u_regfile (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_port_mode(i_port_mode),
    .i_rd_a(i_rd_a),
    .i_rd_b(i_rd_b),
    .i_wr_en(i_rf_wr),
    .i_wr_addr(i_rf_waddr),
    .i_wr_data(i_rf_wdata),
    .i_ptr_en(i_ptr_en),
    .i_ptr_sel(i_ptr_sel),
    .i_ptr_mode(i_ptr_mode),
    .i_ptr_disp(i_ptr_disp),
    .o_rd_a(o_rd_a),
    .o_rd_b(o_rd_b),
    .o_ptr_addr(o_ptr_addr)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.stack_wr = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.irq_ack = 1'b0;
    next_st.first = 1'b0;
    // Flag-type sources latch events; level sources follow the pin
    raw = i_irq_event | (st.flags & ~i_irq_is_level);
    req = raw & i_irq_enable;
    win = lowest_set(req);
    entry_len = i_sleeping ? 4'(ENTRY_CYCLES + SLEEP_EXTRA_CYCLES) : 4'(ENTRY_CYCLES);
    // CLI in this cycle blocks, SEI/IRQ_RETURN_OP guard one more instruction
    take = st.fsm == CSI_RUN && i_insn_done && st.status[BIT_GIE] && !st.hold_one
      && |req && i_op != OP_CLI;
    if (i_insn_done) begin
      next_st.hold_one = 1'b0;
    end
    if (i_alu_valid) begin
      next_st.status[BIT_NEG] = i_alu_result[7];
      next_st.status[BIT_ZERO] = i_alu_result == 8'h00;
      next_st.status[BIT_CARRY] = i_alu_carry;
      if (i_alu_arith) begin
        next_st.status[BIT_OVF] = i_alu_overflow;
      end
    end
    case (st.fsm)
      CSI_RUN: begin
        if (take) begin
          next_st.fsm = CSI_ENTRY;
          next_st.cnt = entry_len - 4'h1;
          next_st.irq_id = win;
          next_st.ret_pc = i_pc;
          next_st.status[BIT_GIE] = 1'b0;
          next_st.irq_ack = 1'b1;
        end else if (i_insn_done) begin
          case (i_op)
            OP_PUSH: next_st.sp = st.sp - 16'h0001;
            OP_POP: next_st.sp = st.sp + 16'h0001;
            OP_CALL: next_st.sp = st.sp - 16'h0002;
            OP_RET: next_st.sp = st.sp + 16'h0002;
            OP_IRQ_RETURN_OP: begin
              next_st.fsm = CSI_RETURN;
              next_st.cnt = 4'(RETURN_CYCLES - 1);
            end
            OP_SEI: begin
              next_st.status[BIT_GIE] = 1'b1;
              next_st.hold_one = 1'b1;
            end
            OP_CLI: next_st.status[BIT_GIE] = 1'b0;
            default: ;
          endcase
        end
      end
      CSI_ENTRY: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1 || st.cnt == 4'h2) begin
          // Return address low byte first, high byte below it
          next_st.stack_wr = 1'b1;
          next_st.stack_addr = st.sp;
          next_st.stack_wdata = st.cnt == 4'h2 ? st.ret_pc[7:0] : 8'(st.ret_pc >> 8);
          next_st.sp = st.sp - 16'h0001;
        end
        if (st.cnt == 4'h0) begin
          next_st.fsm = CSI_RUN;
          next_st.pc_load = 1'b1;
          next_st.pc_value = vector_of(st.irq_id, st.core_ctrl[BIT_VEC_RELOC]);
        end
      end
      CSI_RETURN: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h2) begin
          next_st.sp = st.sp + 16'h0002;
          next_st.pc_value[PC_W-1:8] = i_pop_data[PC_W-9:0];
        end
        if (st.cnt == 4'h1) begin
          next_st.pc_value[7:0] = i_pop_data;
        end
        if (st.cnt == 4'h0) begin
          next_st.fsm = CSI_RUN;
          next_st.pc_load = 1'b1;
          next_st.status[BIT_GIE] = 1'b1;
          next_st.hold_one = 1'b1;
        end
      end
      default: next_st.fsm = CSI_RUN;
    endcase
    if (i_io_wr) begin
      case (i_io_addr)
        IO_SP_LOW: next_st.sp[7:0] = i_io_wdata;
        IO_SP_HIGH: next_st.sp[15:8] = i_io_wdata;
        IO_STATUS: next_st.status = i_io_wdata;
        IO_CORE_CTRL: next_st.core_ctrl = i_io_wdata;
        default: ;
      endcase
    end
    next_st.rdata = 8'h00;
    if (i_io_rd) begin
      case (i_io_addr)
        IO_SP_LOW: next_st.rdata = st.sp[7:0];
        IO_SP_HIGH: next_st.rdata = st.sp[15:8];
        IO_STATUS: next_st.rdata = st.status;
        IO_CORE_CTRL: next_st.rdata = st.core_ctrl;
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.status[BIT_SIGN] = next_st.status[BIT_NEG] ^ next_st.status[BIT_OVF];
    // Set beats clear: a new event wins over a write-one clear
    next_st.flags = (st.flags & ~i_flag_clear_w1) | (i_irq_event & ~i_irq_is_level);
    if (take && !i_irq_is_level[win]) begin
      next_st.flags[win] = i_irq_event[win] & 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.sp <= TOP_OF_DATA_MEMORY;
      st.pc_load <= 1'b1;
      st.first <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_io_rdata = st.rdata;
  assign o_data_is_reg = i_data_addr < 16'(REG_COUNT);
  assign o_stack_pointer = st.sp;
  assign o_stack_wr = st.stack_wr;
  assign o_stack_addr = st.stack_addr;
  assign o_stack_wdata = st.stack_wdata;
  assign o_stall = st.fsm != CSI_RUN;
  assign o_pc_load = st.pc_load;
  // Reset vector shows until the first edge; fuse picks boot start
  assign o_pc_value = st.first ? (i_reset_vector_relocate_fuse ? BOOT_START : '0)
    : st.pc_value;
  assign o_irq_flags = st.flags;
  assign o_irq_ack = st.irq_ack;
  assign o_irq_ack_id = st.irq_id;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_entry_start;
    st.fsm == CSI_RUN && take;
  endsequence
  sequence s_entry_body;
    (st.fsm == CSI_ENTRY) [*4];
  endsequence

  a_entry_len: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (s_entry_start and !i_sleeping) |=> s_entry_body ##1 (st.fsm == CSI_RUN && st.pc_load))
    else $error("entry not four cycles");
  a_entry_gie: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    s_entry_start |=> !st.status[BIT_GIE])
    else $error("global enable kept on entry");
  a_entry_sp: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (s_entry_start and !i_sleeping and !i_io_wr) |=> ##4 (st.sp == $past(st.sp, 5) - 16'h0002))
    else $error("entry stack pointer not minus two");
  a_irq_return_op_len: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.fsm == CSI_RUN && !take && i_insn_done && i_op == OP_IRQ_RETURN_OP && !i_io_wr)
    |=> (st.fsm == CSI_RETURN) [*4] ##1 (st.status[BIT_GIE] && st.sp == $past(st.sp, 5) + 16'h0002))
    else $error("return timing or effect wrong");
  a_cli_block: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.fsm == CSI_RUN && i_op == OP_CLI && i_insn_done && !i_io_wr)
    |=> (!st.irq_ack && !st.status[BIT_GIE]))
    else $error("interrupt taken on global disable");
  a_gie_gate: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st.irq_ack |-> ($past(st.status[BIT_GIE])
    && |($past(i_irq_enable) & (NUM_IRQ'(1) << st.irq_id))))
    else $error("disabled interrupt taken");
  a_prio_low: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.irq_ack && st.irq_id != 3'h0) |-> !$past(req[0]))
    else $error("priority order broken");
  a_sign_xor: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    st.status[BIT_SIGN] == (st.status[BIT_NEG] ^ st.status[BIT_OVF]))
    else $error("sign bit not n xor v");
  a_zero_flag: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_alu_valid && !i_io_wr) |=> st.status[BIT_ZERO] == ($past(i_alu_result) == 8'h00))
    else $error("zero flag wrong");
  a_push_dec: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.fsm == CSI_RUN && !take && i_insn_done && i_op == OP_PUSH && !i_io_wr)
    |=> st.sp == $past(st.sp) - 16'h0001)
    else $error("push did not lower stack pointer");
  a_sei_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.fsm == CSI_RUN && !take && i_insn_done && i_op == OP_SEI) |=> !take)
    else $error("no instruction after enable");
  a_flag_keep: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (st.flags[1] && !i_flag_clear_w1[1] && !take) |=> st.flags[1])
    else $error("flag lost while pending");
endmodule

// [verif/csi_stack_mem_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Stack memory seen from the core
// ----------------------------------------
module csi_stack_mem_model
  import csi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_stack_wr,
  input wire logic [15:0] i_stack_addr,
  input wire logic [7:0] i_stack_wdata,
  input wire logic [15:0] i_stack_pointer,
  input wire logic i_ret_take,
  output logic [7:0] o_pop_data
);
  logic [7:0] mem [0:2047];
  logic [2:0] step_cnt;
  logic [15:0] base;
  logic [7:0] last;

  // Outside the pop window the bus toggles, so a late sample shows up
  always_comb begin
    case (step_cnt)
      3'h2: o_pop_data = mem[base[10:0] + 11'h1];
      3'h3: o_pop_data = mem[base[10:0] + 11'h2];
      default: o_pop_data = ~last;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_stack_wr) begin
      mem[i_stack_addr[10:0]] <= i_stack_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      step_cnt <= 3'h0;
      base <= 16'h0000;
      last <= 8'h00;
    end else begin
      last <= o_pop_data;
      if (i_ret_take) begin
        step_cnt <= 3'h1;
        base <= i_stack_pointer;
      end else if (step_cnt == 3'h4) begin
        step_cnt <= 3'h0;
      end else if (step_cnt != 3'h0) begin
        step_cnt <= step_cnt + 3'h1;
      end
    end
  end
endmodule

// [verif/cpu_stack_interrupt_control_test.sv]
`timescale 1ns/10ps
module cpu_stack_interrupt_control_test
  import csi_pkg::*;
;
  logic i_clock, i_reset_n, i_alu_valid, i_alu_arith, i_alu_carry, i_alu_overflow;
  logic i_insn_done, i_sleeping, i_io_wr, i_io_rd, i_rf_wr, i_ptr_en;
  logic [7:0] i_alu_result, i_io_wdata, i_irq_event, i_irq_is_level, i_irq_enable;
  logic [7:0] i_flag_clear_w1, pop_data, rv, o_io_rdata, o_rd_b, o_stack_wdata, o_irq_flags;
  csi_op_t i_op;
  csi_port_mode_t i_port_mode;
  csi_ptr_mode_t i_ptr_mode;
  logic [PC_W-1:0] i_pc, o_pc_value;
  logic [5:0] i_io_addr, i_ptr_disp;
  logic [15:0] i_data_addr, i_rf_wdata, o_rd_a, o_ptr_addr, o_stack_pointer, o_stack_addr;
  logic [4:0] i_rd_a, i_rd_b, i_rf_waddr;
  logic [1:0] i_ptr_sel;
  logic [2:0] o_irq_ack_id;
  logic o_data_is_reg, o_stack_wr, o_stall, o_pc_load, o_irq_ack, fuse;
  int error_cnt, checks, cyc;

  csi_core_ctrl dut_u (.i_clock, .i_reset_n, .i_reset_vector_relocate_fuse(fuse),
    .i_alu_valid, .i_alu_arith, .i_alu_result, .i_alu_carry, .i_alu_overflow,
    .i_insn_done, .i_sleeping, .i_op, .i_pc, .i_pop_data(pop_data), .i_io_wr, .i_io_rd,
    .i_io_addr, .i_io_wdata, .i_irq_event, .i_irq_is_level, .i_irq_enable, .i_flag_clear_w1,
    .i_data_addr, .i_port_mode, .i_rd_a, .i_rd_b, .i_rf_wr, .i_rf_waddr, .i_rf_wdata,
    .i_ptr_en, .i_ptr_sel, .i_ptr_mode, .i_ptr_disp, .o_io_rdata, .o_rd_a, .o_rd_b,
    .o_ptr_addr, .o_data_is_reg, .o_stack_pointer, .o_stack_wr, .o_stack_addr,
    .o_stack_wdata, .o_stall, .o_pc_load, .o_pc_value, .o_irq_flags, .o_irq_ack,
    .o_irq_ack_id);

  csi_stack_mem_model mdl_u (.i_clock, .i_reset_n, .i_stack_wr(o_stack_wr),
    .i_stack_addr(o_stack_addr), .i_stack_wdata(o_stack_wdata),
    .i_stack_pointer(o_stack_pointer),
    .i_ret_take(i_insn_done && i_op == OP_IRQ_RETURN_OP && !o_stall), .o_pop_data(pop_data));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_io_wr <= 1'b1;
    i_io_addr <= a;
    i_io_wdata <= d;
    @(posedge i_clock);
    i_io_wr <= 1'b0;
  endtask

  task automatic io_rd(input logic [5:0] a);
    @(posedge i_clock);
    i_io_rd <= 1'b1;
    i_io_addr <= a;
    @(posedge i_clock);
    i_io_rd <= 1'b0;
    #1 rv = o_io_rdata;
  endtask

  task automatic alu(input logic [7:0] r, input logic c, input logic v, input logic ar);
    @(posedge i_clock);
    i_alu_valid <= 1'b1;
    i_alu_result <= r;
    i_alu_carry <= c;
    i_alu_overflow <= v;
    i_alu_arith <= ar;
    @(posedge i_clock);
    i_alu_valid <= 1'b0;
  endtask

  // Ends just after the completing edge, while the ack pulse stands
  task automatic step(input csi_op_t o, input logic take);
    @(posedge i_clock);
    i_insn_done <= 1'b1;
    i_op <= o;
    @(posedge i_clock);
    i_insn_done <= 1'b0;
    i_op <= OP_NONE;
    #1 chk(o_irq_ack, take);
  endtask

  task automatic wait_load(input int n_exp, input logic [PC_W-1:0] pc_exp);
    int n;
    n = 1;
    while (o_pc_load !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk(16'(n), 16'(n_exp));
    chk(16'(o_pc_value), 16'(pc_exp));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reg_test;
    io_rd(IO_SP_LOW);
    chk(rv, TOP_OF_DATA_MEMORY[7:0]);
    io_rd(IO_SP_HIGH);
    chk(rv, TOP_OF_DATA_MEMORY[15:8]);
    io_wr(IO_SP_LOW, 8'h00);
    io_wr(IO_SP_HIGH, 8'h03);
    io_rd(IO_SP_HIGH);
    chk(rv, 8'h03);
    chk(o_stack_pointer, 16'h0300);
    io_wr(6'h10, 8'h55);
    io_rd(6'h10);
    chk(rv, 8'h00);
  endtask

  task automatic flag_test;
    alu(8'h80, 1'b1, 1'b1, 1'b1);
    io_rd(IO_STATUS);
    chk(rv & 8'h1f, 8'h0d);
    alu(8'h00, 1'b0, 1'b0, 1'b0);
    io_rd(IO_STATUS);
    chk(rv & 8'h1f, 8'h1a);
    alu(8'h7f, 1'b0, 1'b0, 1'b1);
    io_rd(IO_STATUS);
    chk(rv & 8'h1f, 8'h00);
  endtask

  task automatic stack_test;
    csi_op_t ops[4] = '{OP_PUSH, OP_CALL, OP_POP, OP_RET};
    logic [15:0] sps[4] = '{16'h02ff, 16'h02fd, 16'h02fe, 16'h0300};
    for (int i = 0; i < 4; i++) begin
      step(ops[i], 1'b0);
      chk(o_stack_pointer, sps[i]);
    end
  endtask

  task automatic ptr_test;
    @(posedge i_clock);
    i_rf_wr <= 1'b1;
    i_port_mode <= PORT_R1_W16;
    i_rf_waddr <= PTR_X_LOW;
    i_rf_wdata <= 16'h0120;
    i_data_addr <= 16'h0020;
    @(posedge i_clock);
    i_rf_waddr <= PTR_Z_LOW;
    i_rf_wdata <= 16'h0200;
    i_data_addr <= 16'h001f;
    #1 chk(o_data_is_reg, 1'b1);
    @(posedge i_clock);
    i_rf_wr <= 1'b0;
    i_data_addr <= 16'h0020;
    i_ptr_en <= 1'b1;
    i_ptr_mode <= PTR_POST_INC;
    i_rd_a <= PTR_X_LOW;
    #1 chk(o_data_is_reg, 1'b0);
    chk(o_rd_a, 16'h0120);
    chk(o_ptr_addr, 16'h0120);
    @(posedge i_clock);
    i_ptr_en <= 1'b0;
    i_ptr_sel <= 2'h2;
    i_ptr_mode <= PTR_DISP;
    i_ptr_disp <= 6'h3f;
    #1 chk(o_rd_a, 16'h0121);
    chk(o_ptr_addr, 16'h023f);
    @(posedge i_clock);
    i_port_mode <= PORT_R2_W8;
    i_rd_b <= 5'h1f;
    #1 chk(o_rd_b, 8'h02);
    chk(o_rd_a, 16'h0021);
  endtask

  task automatic irq_test;
    @(posedge i_clock);
    i_irq_enable <= 8'h0a;
    i_irq_event <= 8'h1a;
    @(posedge i_clock);
    i_irq_event <= 8'h00;
    step(OP_NONE, 1'b0);
    chk(o_irq_flags, 8'h1a);
    @(posedge i_clock);
    i_flag_clear_w1 <= 8'h10;
    @(posedge i_clock);
    i_flag_clear_w1 <= 8'h00;
    #1 chk(o_irq_flags, 8'h0a);
    step(OP_SEI, 1'b0);
    step(OP_NONE, 1'b0);
    step(OP_NONE, 1'b1);
    chk(o_irq_ack_id, 3'h1);
    chk(o_stall, 1'b1);
    wait_load(5, 13'h0006);
    chk(o_stall, 1'b0);
    chk(o_irq_flags, 8'h08);
    chk(o_stack_pointer, 16'h02fe);
    chk(mdl_u.mem[11'h300], 8'hbc);
    chk(mdl_u.mem[11'h2ff], 8'h0a);
    io_rd(IO_STATUS);
    chk(rv[BIT_GIE], 1'b0);
    io_wr(IO_CORE_CTRL, 8'h02);
    step(OP_IRQ_RETURN_OP, 1'b0);
    wait_load(5, 13'h0abc);
    chk(o_stack_pointer, 16'h0300);
    io_rd(IO_STATUS);
    chk(rv[BIT_GIE], 1'b1);
    @(posedge i_clock);
    i_sleeping <= 1'b1;
    step(OP_NONE, 1'b0);
    step(OP_NONE, 1'b1);
    chk(o_irq_ack_id, 3'h3);
    wait_load(9, BOOT_START + 13'h000e);
    i_sleeping <= 1'b0;
    step(OP_SEI, 1'b0);
    step(OP_NONE, 1'b0);
    @(posedge i_clock);
    i_irq_event <= 8'h02;
    @(posedge i_clock);
    i_irq_event <= 8'h00;
    step(OP_CLI, 1'b0);
    step(OP_NONE, 1'b0);
    @(posedge i_clock);
    i_flag_clear_w1 <= 8'h02;
    i_irq_is_level <= 8'h04;
    i_irq_event <= 8'h04;
    @(posedge i_clock);
    i_flag_clear_w1 <= 8'h00;
    repeat (2) @(posedge i_clock);
    i_irq_event <= 8'h00;
    #1 chk(o_irq_flags, 8'h00);
    @(posedge i_clock);
    i_irq_enable <= 8'h0e;
    step(OP_SEI, 1'b0);
    step(OP_NONE, 1'b0);
    @(posedge i_clock);
    i_irq_event <= 8'h04;
    step(OP_NONE, 1'b1);
    chk(o_irq_ack_id, 3'h2);
    wait_load(5, BOOT_START + 13'h000a);
    i_irq_event <= 8'h00;
  endtask

  // Mid-run reset with the reset-vector fuse programmed
  task automatic reset_test;
    @(posedge i_clock);
    fuse <= 1'b1;
    i_reset_n <= 1'b0;
    @(posedge i_clock);
    #1 chk(o_pc_load, 1'b1);
    chk(o_pc_value, BOOT_START);
    chk(o_stack_pointer, TOP_OF_DATA_MEMORY);
    @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    io_rd(IO_SP_HIGH);
    chk(rv, TOP_OF_DATA_MEMORY[15:8]);
    chk(o_irq_flags, 8'h00);
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Whole run is well under a thousand cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 4000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    {i_alu_valid, i_alu_arith, i_alu_carry, i_alu_overflow, i_insn_done} = '0;
    {i_sleeping, i_io_wr, i_io_rd, i_rf_wr, i_ptr_en, i_reset_n, fuse} = '0;
    {i_alu_result, i_io_wdata, i_irq_event, i_irq_is_level, i_irq_enable} = '0;
    {i_flag_clear_w1, i_io_addr, i_ptr_disp, i_data_addr, i_rf_wdata} = '0;
    {i_rd_a, i_rd_b, i_rf_waddr, i_ptr_sel} = '0;
    i_op = OP_NONE;
    i_port_mode = PORT_R1_W8;
    i_ptr_mode = PTR_PLAIN;
    i_pc = 13'h0abc;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (7) @(posedge i_clock);
    #1 chk(o_pc_load, 1'b1);
    chk(o_pc_value, 16'h0000);
    chk(o_stack_pointer, TOP_OF_DATA_MEMORY);
    @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    reg_test();
    flag_test();
    stack_test();
    ptr_test();
    irq_test();
    reset_test();
    report_and_stop();
  end
endmodule
